// >>> cmc_pkg.sv
// Shared constants, types and codes for the configuration memory controller.
`default_nettype none
package cmc_pkg;

  // Serial test port instruction register.
  localparam int          CMC_IR_W        = 4;
  localparam logic [3:0]  CMC_IR_CAPTURE  = 4'h1;
  localparam logic [3:0]  CMC_I_SRAM_PRG  = 4'h1;
  localparam logic [3:0]  CMC_I_NV_PRG    = 4'h2;
  localparam logic [3:0]  CMC_I_NV_BG     = 4'h3;
  localparam logic [3:0]  CMC_I_REFRESH   = 4'h4;
  localparam logic [3:0]  CMC_I_SRAM_ERA  = 4'h5;
  localparam logic [3:0]  CMC_I_NV_ERA    = 4'h6;
  localparam logic [3:0]  CMC_I_SRAM_RD   = 4'h7;
  localparam logic [3:0]  CMC_I_NV_RD     = 4'h8;
  localparam logic [3:0]  CMC_I_SET_SEC   = 4'h9;
  localparam logic [3:0]  CMC_I_BYPASS    = 4'hf;

  // Configuration data word.
  localparam int          CMC_DATA_W      = 32;
  localparam logic [31:0] CMC_ZERO_WORD   = 32'h0000_0000;

  // Wishbone register map, byte addresses.
  localparam int          CMC_ADR_W       = 4;
  localparam logic [3:0]  CMC_ADR_CTRL    = 4'h0;
  localparam logic [3:0]  CMC_ADR_STAT    = 4'h4;

  // Control register fields.
  localparam int          CMC_CTRL_HOLD   = 0;
  localparam logic [1:0]  CMC_CTRL_RST    = 2'h3;

  // Status register fields.
  localparam int          CMC_ST_DONE     = 0;
  localparam int          CMC_ST_BUSY     = 1;
  localparam int          CMC_ST_OFFLINE  = 2;
  localparam int          CMC_ST_SRAM_SEC = 3;
  localparam int          CMC_ST_NV_SEC   = 4;
  localparam int          CMC_ST_OVF      = 5;

  // Held state of the user pins while the device is off line.
  localparam logic [1:0]  CMC_HOLD_HIGH   = 2'h0;
  localparam logic [1:0]  CMC_HOLD_LOW    = 2'h1;
  localparam logic [1:0]  CMC_HOLD_TRI    = 2'h2;
  localparam logic [1:0]  CMC_HOLD_KEEP   = 2'h3;

  typedef enum {
    CMC_TLR, CMC_RTI, CMC_SEL_DR, CMC_CAP_DR, CMC_SH_DR, CMC_EX1_DR, CMC_PA_DR,
    CMC_EX2_DR, CMC_UPD_DR, CMC_SEL_IR, CMC_CAP_IR, CMC_SH_IR, CMC_EX1_IR,
    CMC_PA_IR, CMC_EX2_IR, CMC_UPD_IR
  } cmc_tap_t;

  typedef enum {CMC_IDLE, CMC_LOAD, CMC_ERASE} cmc_seq_t;

  // Word queued from the test port toward a configuration memory.
  typedef struct packed {
    logic                  to_nv;
    logic [CMC_DATA_W-1:0] data;
  } cmc_word_t;

endpackage : cmc_pkg
`default_nettype wire

// >>> cmc_top.sv
// Configuration memory controller with serial test port, load sequencer and register slave.
`timescale 1ns/1ps
`default_nettype none

////////////////////////////////////////////////////////////////////////////////
module cmc_fifo #(
  parameter int W     = 33,
  parameter int DEPTH = 8
) (
  // Clock and reset
  input  wire logic         clk_i,
  input  wire logic         rst_i,
  input  wire logic         ce_i,
  // Fill side
  input  wire logic         in_valid_i,
  output logic              in_ready_o,
  input  wire logic [W-1:0] in_data_i,
  // Drain side
  output logic              out_valid_o,
  input  wire logic         out_ready_i,
  output logic [W-1:0]      out_data_o
);
  localparam int AW = $clog2(DEPTH);

  if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0)
  begin : g_bad_depth
    $error("cmc_fifo: DEPTH must be a power of two of at least 2");
  end

  logic [W-1:0] mem_q [DEPTH];
  logic [AW:0]  wp_q;
  logic [AW:0]  rp_q;
  wire          full  = (wp_q[AW] != rp_q[AW]) && (wp_q[AW-1:0] == rp_q[AW-1:0]);
  wire          empty = (wp_q == rp_q);
  wire          push  = ce_i && in_valid_i && !full;
  wire          pop   = ce_i && out_ready_i && !empty;

  assign in_ready_o  = !full;
  assign out_valid_o = !empty;
  assign out_data_o  = mem_q[rp_q[AW-1:0]];

  always_ff @(posedge clk_i)
  begin
    if (push)
    begin
      mem_q[wp_q[AW-1:0]] <= in_data_i;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      wp_q <= '0;
      rp_q <= '0;
    end
    else
    begin
      if (push) wp_q <= wp_q + 1'b1;
      if (pop)  rp_q <= rp_q + 1'b1;
    end
  end
endmodule : cmc_fifo

////////////////////////////////////////////////////////////////////////////////
module cmc_top #(
  parameter int CFG_WORDS  = 16,
  parameter int FIFO_DEPTH = 8
) (
  // Clock, reset, enable
  input  wire logic                        clk_i,
  input  wire logic                        rst_i,
  input  wire logic                        ce_i,
  // Serial test port pins
  input  wire logic                        tck_i,
  input  wire logic                        tms_i,
  input  wire logic                        tdi_i,
  output logic                             tdo_o,
  output logic                             tdo_oe_o,
  // Wishbone slave
  input  wire logic                        wb_cyc_i,
  input  wire logic                        wb_stb_i,
  input  wire logic                        wb_we_i,
  input  wire logic [cmc_pkg::CMC_ADR_W-1:0] wb_adr_i,
  input  wire logic [3:0]                  wb_sel_i,
  input  wire logic [31:0]                 wb_dat_i,
  output logic [31:0]                      wb_dat_o,
  output logic                             wb_ack_o,
  // Device mode and pin control
  output logic                             user_mode_o,
  output logic                             scan_chain_sel_o,
  output logic                             io_hold_o,
  output logic [1:0]                       io_hold_mode_o,
  output logic                             cfg_done_o
);
  import cmc_pkg::*;

  localparam int PW = $clog2(CFG_WORDS);
  localparam logic [PW-1:0] LAST = PW'(CFG_WORDS - 1);

  if (CFG_WORDS < 2 || (CFG_WORDS & (CFG_WORDS - 1)) != 0)
  begin : g_bad_words
    $error("cmc_top: CFG_WORDS must be a power of two of at least 2");
  end

  //////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers; the first stage feeds only the second.
  logic tck_s1_q, tck_s2_q, tck_s3_q, tms_s1_q, tms_s2_q, tdi_s1_q, tdi_s2_q;

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      // The chains reset to the idle pin levels, tck and tms high and tdi low, so no false test clock edge follows reset.
      {tck_s1_q, tck_s2_q, tck_s3_q} <= 3'h7;
      {tms_s1_q, tms_s2_q, tdi_s1_q, tdi_s2_q} <= 4'hc;
    end
    else if (ce_i)
    begin
      {tck_s1_q, tck_s2_q, tck_s3_q} <= {tck_i, tck_s1_q, tck_s2_q};
      {tms_s1_q, tms_s2_q} <= {tms_i, tms_s1_q};
      {tdi_s1_q, tdi_s2_q} <= {tdi_i, tdi_s1_q};
    end
  end

  wire tck_rise = ce_i && tck_s2_q && !tck_s3_q;
  wire tck_fall = ce_i && !tck_s2_q && tck_s3_q;

  //////////////////////////////////////////////////////////////////////////////
  // Test port controller.
  function automatic cmc_tap_t tap_next(input cmc_tap_t s, input logic m);
    unique case (s)
      CMC_TLR:    tap_next = m ? CMC_TLR    : CMC_RTI;
      CMC_RTI:    tap_next = m ? CMC_SEL_DR : CMC_RTI;
      CMC_SEL_DR: tap_next = m ? CMC_SEL_IR : CMC_CAP_DR;
      CMC_CAP_DR: tap_next = m ? CMC_EX1_DR : CMC_SH_DR;
      CMC_SH_DR:  tap_next = m ? CMC_EX1_DR : CMC_SH_DR;
      CMC_EX1_DR: tap_next = m ? CMC_UPD_DR : CMC_PA_DR;
      CMC_PA_DR:  tap_next = m ? CMC_EX2_DR : CMC_PA_DR;
      CMC_EX2_DR: tap_next = m ? CMC_UPD_DR : CMC_SH_DR;
      CMC_UPD_DR: tap_next = m ? CMC_SEL_DR : CMC_RTI;
      CMC_SEL_IR: tap_next = m ? CMC_TLR    : CMC_CAP_IR;
      CMC_CAP_IR: tap_next = m ? CMC_EX1_IR : CMC_SH_IR;
      CMC_SH_IR:  tap_next = m ? CMC_EX1_IR : CMC_SH_IR;
      CMC_EX1_IR: tap_next = m ? CMC_UPD_IR : CMC_PA_IR;
      CMC_PA_IR:  tap_next = m ? CMC_EX2_IR : CMC_PA_IR;
      CMC_EX2_IR: tap_next = m ? CMC_UPD_IR : CMC_SH_IR;
      CMC_UPD_IR: tap_next = m ? CMC_SEL_DR : CMC_RTI;
    endcase
  endfunction : tap_next

  cmc_tap_t              tap_q;
  logic [CMC_IR_W-1:0]   ir_q, ir_sh_q;
  logic [CMC_DATA_W-1:0] dr_q;
  logic                  bp_q;
  logic [PW-1:0]         rptr_q, wptr_q;
  logic [CMC_DATA_W-1:0] sram_q [CFG_WORDS];
  logic [CMC_DATA_W-1:0] nv_q   [CFG_WORDS];
  logic                  sram_sec_q, nv_sec_q;

  wire upd_ir   = tck_rise && (tap_q == CMC_UPD_IR);
  wire upd_dr   = tck_rise && (tap_q == CMC_UPD_DR);
  wire prg_ir   = (ir_q == CMC_I_SRAM_PRG) || (ir_q == CMC_I_NV_PRG) || (ir_q == CMC_I_NV_BG);
  wire rd_ir    = (ir_q == CMC_I_SRAM_RD) || (ir_q == CMC_I_NV_RD);
  wire data_ir  = prg_ir || rd_ir;
  wire rd_sram  = (ir_q == CMC_I_SRAM_RD);
  wire [CMC_DATA_W-1:0] rd_word = rd_sram ? (sram_sec_q ? CMC_ZERO_WORD : sram_q[rptr_q])
                                          : (nv_sec_q ? CMC_ZERO_WORD : nv_q[rptr_q]);

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      tap_q   <= CMC_TLR;
      ir_q    <= CMC_I_BYPASS;
      ir_sh_q <= CMC_IR_CAPTURE;
      dr_q    <= CMC_ZERO_WORD;
      bp_q    <= 1'b0;
      rptr_q  <= '0;
    end
    else if (tck_rise)
    begin
      tap_q <= tap_next(tap_q, tms_s2_q);
      unique case (tap_q)
        CMC_TLR:    ir_q    <= CMC_I_BYPASS;
        CMC_CAP_IR: ir_sh_q <= CMC_IR_CAPTURE;
        CMC_SH_IR:  ir_sh_q <= {tdi_s2_q, ir_sh_q[CMC_IR_W-1:1]};
        CMC_UPD_IR:
        begin
          ir_q   <= ir_sh_q;
          rptr_q <= '0;
        end
        CMC_CAP_DR:
        begin
          bp_q <= 1'b0;
          if (rd_ir)
          begin
            dr_q   <= rd_word;
            rptr_q <= rptr_q + 1'b1;
          end
        end
        CMC_SH_DR:
        begin
          bp_q <= tdi_s2_q;
          dr_q <= {tdi_s2_q, dr_q[CMC_DATA_W-1:1]};
        end
        default: ;
      endcase
    end
  end

  // The serial output changes on the falling test clock, as the standard requires.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      tdo_o    <= 1'b0;
      tdo_oe_o <= 1'b0;
    end
    else if (tck_fall)
    begin
      tdo_o    <= (tap_q == CMC_SH_IR) ? ir_sh_q[0] : (data_ir ? dr_q[0] : bp_q);
      tdo_oe_o <= (tap_q == CMC_SH_IR) || (tap_q == CMC_SH_DR);
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Word queue between the test port and the memories.
  cmc_word_t in_word, out_word;
  logic      in_ready, out_valid;
  cmc_seq_t  seq_q;
  wire       drain = (seq_q == CMC_IDLE);

  assign in_word.to_nv = (ir_q != CMC_I_SRAM_PRG);
  assign in_word.data  = dr_q;

  cmc_fifo #(.W($bits(cmc_word_t)), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk_i       (clk_i),
    .rst_i       (rst_i),
    .ce_i        (ce_i),
    .in_valid_i  (upd_dr && prg_ir),
    .in_ready_o  (in_ready),
    .in_data_i   (in_word),
    .out_valid_o (out_valid),
    .out_ready_i (drain),
    .out_data_o  (out_word)
  );

  //////////////////////////////////////////////////////////////////////////////
  // Load, refresh and erase sequencer with memory write ports.
  logic [PW-1:0] cnt_q;
  logic          era_nv_q, done_q, ovf_q;
  wire           pop      = drain && out_valid;
  wire           cmd_ok   = upd_ir && (seq_q == CMC_IDLE);
  wire           seq_end  = (seq_q != CMC_IDLE) && (cnt_q == LAST);
  wire           sram_we  = (seq_q == CMC_LOAD) || ((seq_q == CMC_ERASE) && !era_nv_q)
                            || (pop && !out_word.to_nv);
  wire [PW-1:0]  sram_wa  = (seq_q == CMC_IDLE) ? wptr_q : cnt_q;
  wire [CMC_DATA_W-1:0] sram_wd = (seq_q == CMC_LOAD) ? nv_q[cnt_q]
                                  : ((seq_q == CMC_ERASE) ? CMC_ZERO_WORD : out_word.data);
  wire           nv_we    = ((seq_q == CMC_ERASE) && era_nv_q) || (pop && out_word.to_nv);
  wire [CMC_DATA_W-1:0] nv_wd = (seq_q == CMC_ERASE) ? CMC_ZERO_WORD : out_word.data;

  always_ff @(posedge clk_i)
  begin
    if (ce_i && sram_we) sram_q[sram_wa] <= sram_wd;
    if (ce_i && nv_we)   nv_q[sram_wa]   <= nv_wd;
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      seq_q      <= CMC_LOAD;
      cnt_q      <= '0;
      era_nv_q   <= 1'b0;
      done_q     <= 1'b0;
      wptr_q     <= '0;
      sram_sec_q <= 1'b0;
      nv_sec_q   <= 1'b0;
    end
    else if (ce_i)
    begin
      if (upd_ir) wptr_q <= '0;
      else if (pop) wptr_q <= wptr_q + 1'b1;
      if (pop && !out_word.to_nv && wptr_q == LAST) done_q <= 1'b1;
      if (seq_q != CMC_IDLE) cnt_q <= cnt_q + 1'b1;
      if (seq_end)
      begin
        seq_q <= CMC_IDLE;
        if (seq_q == CMC_LOAD) done_q <= 1'b1;
        else if (era_nv_q) nv_sec_q <= 1'b0;
        else sram_sec_q <= 1'b0;
      end
      else if (cmd_ok)
      begin
        cnt_q <= '0;
        if (ir_sh_q == CMC_I_REFRESH)
        begin
          seq_q  <= CMC_LOAD;
          done_q <= 1'b0;
        end
        else if (ir_sh_q == CMC_I_SRAM_ERA || ir_sh_q == CMC_I_NV_ERA)
        begin
          seq_q    <= CMC_ERASE;
          era_nv_q <= (ir_sh_q == CMC_I_NV_ERA);
          if (ir_sh_q == CMC_I_SRAM_ERA) done_q <= 1'b0;
        end
        else if (ir_sh_q == CMC_I_SET_SEC)
        begin
          sram_sec_q <= 1'b1;
          nv_sec_q   <= 1'b1;
        end
        else if (ir_sh_q == CMC_I_SRAM_PRG) done_q <= 1'b0;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Mode outputs. Background programming and non-volatile erase keep user mode.
  wire offline = (seq_q == CMC_LOAD) || ((seq_q == CMC_ERASE) && !era_nv_q)
                 || (ir_q == CMC_I_SRAM_PRG) || (ir_q == CMC_I_NV_PRG);
  logic [1:0] hold_sel_q;

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      user_mode_o      <= 1'b0;
      scan_chain_sel_o <= 1'b0;
      io_hold_o        <= 1'b0;
      io_hold_mode_o   <= CMC_CTRL_RST;
      cfg_done_o       <= 1'b0;
    end
    else if (ce_i)
    begin
      user_mode_o      <= !offline && done_q;
      scan_chain_sel_o <= offline && (ir_q == CMC_I_NV_PRG);
      io_hold_o        <= offline;
      io_hold_mode_o   <= hold_sel_q;
      cfg_done_o       <= done_q;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Wishbone slave. Ack comes one cycle after the strobe and drops the next.
  wire        wb_req  = wb_cyc_i && wb_stb_i && !wb_ack_o;
  wire        wb_wr   = wb_req && wb_we_i && wb_sel_i[0];
  wire        hit_ctl = (wb_adr_i == CMC_ADR_CTRL);
  wire        hit_st  = (wb_adr_i == CMC_ADR_STAT);
  wire        ovf_set = upd_dr && prg_ir && !in_ready;
  wire        ovf_clr = wb_wr && hit_st && wb_dat_i[CMC_ST_OVF];
  wire [31:0] stat_w  = 32'(({ovf_q, nv_sec_q, sram_sec_q, offline,
                             (seq_q != CMC_IDLE), done_q}) << CMC_ST_DONE);
  wire [31:0] rd_mux  = hit_ctl ? 32'(hold_sel_q) : (hit_st ? stat_w : 32'h0000_0000);

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      wb_ack_o   <= 1'b0;
      wb_dat_o   <= 32'h0000_0000;
      hold_sel_q <= CMC_CTRL_RST;
      ovf_q      <= 1'b0;
    end
    else if (ce_i)
    begin
      wb_ack_o <= wb_req;
      wb_dat_o <= wb_req ? rd_mux : 32'h0000_0000;
      if (wb_wr && hit_ctl) hold_sel_q <= wb_dat_i[CMC_CTRL_HOLD +: 2];
      if (ovf_set) ovf_q <= 1'b1;
      else if (ovf_clr) ovf_q <= 1'b0;
    end
  end
endmodule : cmc_top
`default_nettype wire

// >>> cmc_top_props.sv
// Concurrent checks on the configuration memory controller ports.
`timescale 1ns/1ps
`default_nettype none
module cmc_top_props #(
  parameter int CFG_WORDS  = 16,
  parameter int FIFO_DEPTH = 8
) (
  // Clock and reset
  input wire logic        clk_i,
  input wire logic        rst_i,
  input wire logic        ce_i,
  // Test port
  input wire logic        tck_i,
  input wire logic        tdo_o,
  input wire logic        tdo_oe_o,
  // Wishbone
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_we_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic        wb_ack_o,
  // Mode outputs
  input wire logic        user_mode_o,
  input wire logic        scan_chain_sel_o,
  input wire logic        io_hold_o,
  input wire logic [1:0]  io_hold_mode_o,
  input wire logic        cfg_done_o
);
  import cmc_pkg::*;
  // Registered outputs add a few cycles to the load.
  localparam int LOAD_MAX = CFG_WORDS + 4;
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  a_ack_answer: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o && ce_i |=> wb_ack_o)
    else $error("bus request not answered");
  a_ack_once: assert property (wb_ack_o && ce_i |=> !wb_ack_o)
    else $error("bus ack longer than one cycle");
  a_dat_idle: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
    else $error("read data outside ack");
  a_hold_write: assert property ($changed(io_hold_mode_o) |-> $past(wb_we_i) && $past(wb_stb_i))
    else $error("hold mode changed without a write");
  a_offline_user: assert property (io_hold_o && $past(io_hold_o) |-> !user_mode_o)
    else $error("user mode while pins held");
  a_scan_offline: assert property (scan_chain_sel_o && $past(scan_chain_sel_o) |-> io_hold_o && !user_mode_o)
    else $error("scan chain in control while online");
  a_user_rise: assert property ($rose(user_mode_o) |-> cfg_done_o && !io_hold_o)
    else $error("user mode without configuration");
  a_load_powerup: assert property ($fell(rst_i) |=> io_hold_o && !user_mode_o ##[1:LOAD_MAX] cfg_done_o && user_mode_o)
    else $error("power-up load missing or late");
  a_tdo_fall: assert property ($changed(tdo_o) || $changed(tdo_oe_o) |-> !$past(tck_i, 2))
    else $error("test data out moved off the falling test clock");
endmodule : cmc_top_props
////////////////////////////////////////////////////////////
bind cmc_top cmc_top_props #(.CFG_WORDS(CFG_WORDS), .FIFO_DEPTH(FIFO_DEPTH)) u_props (
  .clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .tck_i(tck_i), .tdo_o(tdo_o),
  .tdo_oe_o(tdo_oe_o), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
  .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .user_mode_o(user_mode_o),
  .scan_chain_sel_o(scan_chain_sel_o), .io_hold_o(io_hold_o),
  .io_hold_mode_o(io_hold_mode_o), .cfg_done_o(cfg_done_o)
);
`default_nettype wire

// >>> cmc_host_model.sv
// Serial test port host that walks the port controller and shifts registers.
`timescale 1ns/1ps
`default_nettype none
module cmc_host_model (
  // Clock
  input  wire logic clk_i,
  // Test port
  input  wire logic tdo_i,
  output logic      tck_o,
  output logic      tms_o,
  output logic      tdi_o
);
  initial
  begin
    tck_o = 1'b1;
    tms_o = 1'b1;
    tdi_o = 1'b0;
  end
  // One test clock of eight system clocks; outside shifts tdi carries no data, so it toggles.
  task automatic bit_io(input logic m, input logic d, output logic q);
    tck_o <= 1'b0;
    tms_o <= m;
    tdi_o <= d;
    repeat (3) @(posedge clk_i);
    @(negedge clk_i);
    q = tdo_i;
    @(posedge clk_i);
    tck_o <= 1'b1;
    repeat (4) @(posedge clk_i);
  endtask : bit_io
  // From idle through capture, n bits LSB first, update, back to idle.
  task automatic shift(input logic ir, input logic [31:0] din, input int n,
                       output logic [31:0] dout);
    logic q;
    dout = 32'h0;
    bit_io(1'b1, ~tdi_o, q);
    if (ir)
      bit_io(1'b1, ~tdi_o, q);
    bit_io(1'b0, ~tdi_o, q);
    bit_io(1'b0, ~tdi_o, q);
    for (int i = 0; i < n; i++)
    begin
      bit_io(i == n - 1, din[i], q);
      dout[i] = q;
    end
    bit_io(1'b1, ~tdi_o, q);
    bit_io(1'b0, ~tdi_o, q);
  endtask : shift
endmodule : cmc_host_model
`default_nettype wire

// >>> tb_config_memory_controller.sv
// Self-checking bench for the configuration memory controller.
`timescale 1ns/1ps
`default_nettype none
`define CMC_CHECK(got, exp) \
  begin \
    n_compared++; \
    if ((got) !== (exp)) \
    begin \
      errors++; \
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp); \
    end \
  end
module tb_config_memory_controller;
  import cmc_pkg::*;
  logic        clk_i, rst_i, ce_i, tck_i, tms_i, tdi_i, tdo_o, tdo_oe_o;
  logic        wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, hold_q, ok;
  logic        user_mode_o, scan_chain_sel_o, io_hold_o, cfg_done_o;
  logic [3:0]  wb_adr_i, wb_sel_i;
  logic [1:0]  io_hold_mode_o;
  logic [31:0] wb_dat_i, wb_dat_o, rd, cap, d;
  int          errors = 0, n_compared = 0, n_off = 0, cnt;

  initial
  begin
    clk_i = 1'b0;
    forever #50 clk_i = ~clk_i;
  end
  // Counts entries into the held state, so short offline spells are not missed.
  always @(posedge clk_i)
  begin
    hold_q <= io_hold_o;
    if (io_hold_o && !hold_q)
      n_off <= n_off + 1;
  end

  cmc_top #(.CFG_WORDS(16), .FIFO_DEPTH(8)) dut (
    .clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .tck_i(tck_i), .tms_i(tms_i),
    .tdi_i(tdi_i), .tdo_o(tdo_o), .tdo_oe_o(tdo_oe_o), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
    .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .user_mode_o(user_mode_o), .scan_chain_sel_o(scan_chain_sel_o),
    .io_hold_o(io_hold_o), .io_hold_mode_o(io_hold_mode_o), .cfg_done_o(cfg_done_o)
  );
  cmc_host_model host (.clk_i(clk_i), .tdo_i(tdo_o), .tck_o(tck_i), .tms_o(tms_i),
                       .tdi_o(tdi_i));

  ////////////////////////////////////////////////////////////
  task automatic summarize();
    $display("compared %0d, mismatches %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : summarize
  task automatic wb(input logic we, input logic [3:0] adr, input logic [31:0] wd);
    int k;
    k = 0;
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_sel_i <= 4'hf;
    wb_we_i  <= we;
    wb_adr_i <= adr;
    wb_dat_i <= wd;
    do
    begin
      @(posedge clk_i);
      k++;
    end
    while (wb_ack_o !== 1'b1 && k < 20);
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    @(posedge clk_i);
    if (k >= 20)
    begin
      errors++;
      summarize();
    end
  endtask : wb
  // Polls status until the load sequencer is idle; rd then holds status.
  task automatic idle();
    int k;
    k = 0;
    do
    begin
      wb(1'b0, CMC_ADR_STAT, 32'h0);
      k++;
    end
    while (rd[CMC_ST_BUSY] !== 1'b0 && k < 40);
    if (k >= 40)
    begin
      errors++;
      summarize();
    end
  endtask : idle
  task automatic ir(input logic [3:0] code);
    host.shift(1'b1, {28'h0, code}, 4, cap);
    // Mode outputs are registered behind the instruction update; let them settle.
    repeat (2) @(posedge clk_i);
  endtask : ir
  task automatic words(input logic [31:0] base, input logic chk);
    ok = 1'b1;
    for (int i = 0; i < 16; i++)
    begin
      host.shift(1'b0, base + 32'(i), 32, d);
      if (chk && d !== base + 32'(i))
        ok = 1'b0;
    end
  endtask : words

  ////////////////////////////////////////////////////////////
  task automatic t_powerup();
    repeat (2) @(posedge clk_i);
    `CMC_CHECK({io_hold_o, user_mode_o}, 2'b10)
    // The port controller starts in its reset state; one low select bit reaches idle.
    host.bit_io(1'b0, 1'b0, ok);
    ir(CMC_I_BYPASS);
    `CMC_CHECK(cap[3:0], CMC_IR_CAPTURE)
    `CMC_CHECK(tdo_oe_o, 1'b0)
    `CMC_CHECK({cfg_done_o, user_mode_o, io_hold_o}, 3'b110)
    wb(1'b0, CMC_ADR_CTRL, 32'h0);
    `CMC_CHECK(rd[1:0], CMC_CTRL_RST)
  endtask : t_powerup
  task automatic t_hold();
    for (int m = 3; m >= 0; m--)
    begin
      wb(1'b1, CMC_ADR_CTRL, 32'(m));
      `CMC_CHECK(io_hold_mode_o, 2'(m))
    end
    wb(1'b1, 4'h8, 32'hffff_ffff);
    wb(1'b0, 4'h8, 32'h0);
    `CMC_CHECK(rd, CMC_ZERO_WORD)
    wb(1'b1, CMC_ADR_CTRL, {30'h0, CMC_HOLD_LOW});
  endtask : t_hold
  task automatic t_sram();
    ir(CMC_I_SRAM_PRG);
    `CMC_CHECK({io_hold_o, scan_chain_sel_o, user_mode_o, io_hold_mode_o}, {3'b100, CMC_HOLD_LOW})
    words(32'h5a5a_0000, 1'b0);
    ir(CMC_I_SRAM_RD);
    words(32'h5a5a_0000, 1'b1);
    `CMC_CHECK(ok, 1'b1)
    ir(CMC_I_BYPASS);
    `CMC_CHECK({cfg_done_o, user_mode_o, io_hold_o}, 3'b110)
  endtask : t_sram
  task automatic t_nv();
    ir(CMC_I_NV_PRG);
    `CMC_CHECK({io_hold_o, scan_chain_sel_o, user_mode_o}, 3'b110)
    words(32'h3c3c_8000, 1'b0);
    ir(CMC_I_NV_RD);
    words(32'h3c3c_8000, 1'b1);
    `CMC_CHECK(ok, 1'b1)
    ir(CMC_I_NV_BG);
    `CMC_CHECK({io_hold_o, scan_chain_sel_o, user_mode_o}, 3'b001)
    words(32'h96e1_0000, 1'b0);
    `CMC_CHECK(user_mode_o, 1'b1)
    ir(CMC_I_NV_RD);
    words(32'h96e1_0000, 1'b1);
    `CMC_CHECK(ok, 1'b1)
    cnt = n_off;
    ir(CMC_I_REFRESH);
    idle();
    `CMC_CHECK(n_off, cnt + 1)
    ir(CMC_I_SRAM_RD);
    words(32'h96e1_0000, 1'b1);
    `CMC_CHECK(ok, 1'b1)
  endtask : t_nv
  task automatic t_sec();
    ir(CMC_I_SET_SEC);
    ir(CMC_I_SRAM_RD);
    host.shift(1'b0, 32'h0, 32, d);
    `CMC_CHECK(d, CMC_ZERO_WORD)
    ir(CMC_I_NV_RD);
    host.shift(1'b0, 32'h0, 32, d);
    `CMC_CHECK(d, CMC_ZERO_WORD)
    idle();
    `CMC_CHECK(rd[4:3], 2'b11)
    ir(CMC_I_SRAM_ERA);
    idle();
    `CMC_CHECK({rd[4:3], rd[0]}, 3'b100)
    ir(CMC_I_NV_ERA);
    idle();
    `CMC_CHECK(rd[4:3], 2'b00)
  endtask : t_sec

  initial
  begin
    rst_i = 1'b1;
    ce_i = 1'b1;
    wb_cyc_i = 1'b0;
    wb_stb_i = 1'b0;
    wb_we_i = 1'b0;
    wb_adr_i = 4'h0;
    wb_sel_i = 4'hf;
    wb_dat_i = 32'h0;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    t_powerup();
    t_hold();
    t_sram();
    t_nv();
    t_sec();
    summarize();
  end
endmodule : tb_config_memory_controller
`default_nettype wire
